// File: design/edi_pkg.sv
package edi_pkg;
  // Register byte offsets
  localparam logic [7:0] EDI_OFS_RAW     = 8'h00;
  localparam logic [7:0] EDI_OFS_MASKED  = 8'h04;
  localparam logic [7:0] EDI_OFS_ENABLE  = 8'h08;
  localparam logic [7:0] EDI_OFS_CTRL    = 8'h0C;
  localparam logic [7:0] EDI_OFS_DMA_ST  = 8'h10;
  localparam logic [7:0] EDI_OFS_POLL    = 8'h14;
  localparam logic [7:0] EDI_OFS_TS_STAT = 8'h18;
  localparam logic [7:0] EDI_OFS_TS_TGT  = 8'h1C;
  localparam logic [7:0] EDI_OFS_NADDR   = 8'h20;

  // Status bit positions
  localparam int EDI_NSRC   = 15;
  localparam int EDI_S_TXC  = 0;
  localparam int EDI_S_TXS  = 1;
  localparam int EDI_S_TXNB = 2;
  localparam int EDI_S_JAB  = 3;
  localparam int EDI_S_ROVF = 4;
  localparam int EDI_S_TUNF = 5;
  localparam int EDI_S_RXC  = 6;
  localparam int EDI_S_RXNB = 7;
  localparam int EDI_S_RXS  = 8;
  localparam int EDI_S_RWD  = 9;
  localparam int EDI_S_ETX  = 10;
  localparam int EDI_S_BERR = 11;
  localparam int EDI_S_ERX  = 12;
  localparam int EDI_S_PHY  = 13;
  localparam int EDI_S_TS   = 14;
  localparam int EDI_S_ABN  = 15;
  localparam int EDI_S_NRM  = 16;

  // Summary membership
  localparam logic [14:0] EDI_NRM_MASK = 15'h1045;
  localparam logic [14:0] EDI_ABN_MASK = 15'h0FBA;

  // Control and poll bit positions
  localparam int EDI_C_DMA   = 0;
  localparam int EDI_C_TXGO  = 1;
  localparam int EDI_C_RXGO  = 2;
  localparam int EDI_C_JUMBO = 3;
  localparam int EDI_P_TX    = 0;
  localparam int EDI_P_RX    = 1;

  // Frame length limits: 2048 and 10240 bytes
  localparam logic [13:0] EDI_LEN_STD   = 14'h0800;
  localparam logic [13:0] EDI_LEN_JUMBO = 14'h2800;
  localparam logic [13:0] EDI_CNT_SAT   = 14'h3FFF;

  // Perfect-filter address slots, plain default
  localparam logic [7:0] EDI_NUM_ADDR = 8'h04;

  typedef enum logic [1:0] {
    EDI_PROC_STOP = 2'b00,
    EDI_PROC_RUN  = 2'b01,
    EDI_PROC_SUSP = 2'b10
  } edi_proc_t;

  // Event pulses from the DMA, FIFOs and timestamp unit
  typedef struct packed {
    logic       tx_wb_done;
    logic       rx_wb_done;
    logic       rx_first_buf;
    logic       tx_in_fifo;
    logic       rx_ovf;
    logic       tx_unf;
    logic       rx_desc_host;
    logic       tx_desc_host;
    logic       bus_err;
    logic [2:0] err_cause;
    logic       rx_byte;
    logic       rx_end;
    logic       tx_byte;
    logic       tx_end;
    logic       ts_evt;
    logic       ts_tgt;
    logic [3:0] ts_cause;
  } edi_evt_t;

  typedef struct packed {
    logic [14:0] flag;
    logic [16:0] en;
    logic        dma_en;
    logic        tx_go;
    logic        rx_go;
    logic        jumbo;
    logic        ts_tgt_en;
    edi_proc_t   tx_p;
    edi_proc_t   rx_p;
    logic [2:0]  err_cause;
    logic [3:0]  ts_cause;
    logic [13:0] rx_cnt;
    logic [13:0] tx_cnt;
    logic        phy_s1;
    logic        phy_s2;
    logic        phy_prev;
    logic        tx_abort;
    logic        irq;
    logic [31:0] rd_data;
  } edi_state_t;

  localparam edi_state_t EDI_ST_RST = '0;
endpackage : edi_pkg

// File: design/edi_irq_logic.sv
`timescale 1ns/1ps
// Function
// - Only enabled sources reach the interrupt line
// - Status readable raw or masked per read
// - Normal summary ORs four masked sources
// - Abnormal summary ORs nine masked sources
// - Bus error flags, disables DMA, keeps cause
// - Early receive on first buffer filled
// - Early transmit when frame reaches FIFO
// - Receive watchdog beyond 2048 or 10240 bytes
// - Jabber beyond limit aborts, stops transmit
// - Host-owned rx descriptor flags, suspends receive
// - Host-owned tx descriptor flags, suspends transmit
// - Receive complete after descriptor status written
// - Transmit complete after descriptor status updated
// - Underflow flags and suspends transmit
// - Receive overflow raises its flag
// - Stopped flags on entering stop state
// - PHY interrupt raises PHY flag
// - Timestamp flag, cleared by timestamp status read
// - Timestamp targets have separate enable
// - Report number of address slots
// - Selective clear; summaries follow constituents
module edi_irq_logic (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  // Register port
  input  wire logic [7:0]       addr_in,
  input  wire logic [31:0]      wr_data_in,
  input  wire logic             wr_en_in,
  input  wire logic             rd_en_in,
  output logic      [31:0]      rd_data_out,
  // Events and PHY pin
  input  edi_pkg::edi_evt_t     evt_in,
  input  wire logic             phy_irq_in,
  // Processor request and DMA control
  output logic                  irq_out,
  output logic                  dma_en_out,
  output edi_pkg::edi_proc_t    tx_proc_out,
  output edi_pkg::edi_proc_t    rx_proc_out,
  output logic                  tx_abort_out
);
  import edi_pkg::*;

  // State register and its next value
  edi_state_t  st_r;
  edi_state_t  st_nxt;

  // Per-source gating, clears and summaries
  logic [14:0] masked;
  logic [14:0] w1c;
  logic [14:0] flag_nxt;
  logic        nrm_sum;
  logic        abn_sum;
  logic        nrm_gated;
  logic        abn_gated;

  // Register strobe decode
  logic        wr_raw;
  logic        wr_en_reg;
  logic        wr_ctrl;
  logic        wr_poll;
  logic        wr_tgt;
  logic        rd_ts;
  logic        poll_tx;
  logic        poll_rx;

  // Event set vector and length checks
  logic [14:0] set_v;
  logic [13:0] lim;
  logic        rx_cnt_inc;
  logic        tx_cnt_inc;
  logic        rwd_hit;
  logic        jab_hit;

  // Read path
  logic [31:0] rd_mux;

  // Per-source gating, write-one-to-clear, set beats clear
  genvar i;
  generate
    for (i = 0; i < EDI_NSRC; i++) begin : g_src
      assign masked[i] = st_r.flag[i] & st_r.en[i];
      assign w1c[i]    = wr_raw & wr_data_in[i];
      assign flag_nxt[i] = (st_r.flag[i] & ~w1c[i]) | set_v[i];
    end
  endgenerate

  // Summaries from masked constituents only
  assign nrm_sum = |(masked & EDI_NRM_MASK);
  assign abn_sum = |(masked & EDI_ABN_MASK);

  // Summaries gated by their own enables
  assign nrm_gated = nrm_sum & st_r.en[EDI_S_NRM];
  assign abn_gated = abn_sum & st_r.en[EDI_S_ABN];

  // Address decode
  assign wr_raw    = wr_en_in && (addr_in == EDI_OFS_RAW);
  assign wr_en_reg = wr_en_in && (addr_in == EDI_OFS_ENABLE);
  assign wr_ctrl   = wr_en_in && (addr_in == EDI_OFS_CTRL);
  assign wr_poll   = wr_en_in && (addr_in == EDI_OFS_POLL);
  assign wr_tgt    = wr_en_in && (addr_in == EDI_OFS_TS_TGT);
  assign rd_ts     = rd_en_in && (addr_in == EDI_OFS_TS_STAT);
  assign poll_tx   = wr_poll && wr_data_in[EDI_P_TX];
  assign poll_rx   = wr_poll && wr_data_in[EDI_P_RX];

  // Frame length limit and overrun detection
  assign lim     = st_r.jumbo ? EDI_LEN_JUMBO : EDI_LEN_STD;
  assign rwd_hit = evt_in.rx_byte && (st_r.rx_cnt == lim);
  assign jab_hit = evt_in.tx_byte && (st_r.tx_cnt == lim);
  assign rx_cnt_inc = evt_in.rx_byte && (st_r.rx_cnt != EDI_CNT_SAT);
  assign tx_cnt_inc = evt_in.tx_byte && (st_r.tx_cnt != EDI_CNT_SAT);

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_in)
      // Raw flags; summaries ignore their own enables
      EDI_OFS_RAW: begin
        rd_mux[14:0]      = st_r.flag;
        rd_mux[EDI_S_ABN] = abn_sum;
        rd_mux[EDI_S_NRM] = nrm_sum;
      end
      EDI_OFS_MASKED: begin
        rd_mux[14:0]      = masked;
        rd_mux[EDI_S_ABN] = abn_gated;
        rd_mux[EDI_S_NRM] = nrm_gated;
      end
      EDI_OFS_ENABLE: begin
        rd_mux[16:0] = st_r.en;
      end
      EDI_OFS_CTRL: begin
        rd_mux[EDI_C_DMA]   = st_r.dma_en;
        rd_mux[EDI_C_TXGO]  = st_r.tx_go;
        rd_mux[EDI_C_RXGO]  = st_r.rx_go;
        rd_mux[EDI_C_JUMBO] = st_r.jumbo;
      end
      EDI_OFS_DMA_ST: begin
        rd_mux[1:0] = st_r.tx_p;
        rd_mux[3:2] = st_r.rx_p;
        rd_mux[6:4] = st_r.err_cause;
      end
      EDI_OFS_TS_STAT: begin
        rd_mux[3:0] = st_r.ts_cause;
      end
      EDI_OFS_TS_TGT: begin
        rd_mux[0] = st_r.ts_tgt_en;
      end
      // Slot count is a fixed constant
      EDI_OFS_NADDR: begin
        rd_mux[7:0] = EDI_NUM_ADDR;
      end
      // Unmapped offsets read as zero
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Event set vector
  always_comb begin
    set_v = 15'h0000;
    set_v[EDI_S_TXC]  = evt_in.tx_wb_done;
    set_v[EDI_S_RXC]  = evt_in.rx_wb_done;
    set_v[EDI_S_ERX]  = evt_in.rx_first_buf;
    set_v[EDI_S_ETX]  = evt_in.tx_in_fifo;
    set_v[EDI_S_ROVF] = evt_in.rx_ovf;
    set_v[EDI_S_TUNF] = evt_in.tx_unf;
    set_v[EDI_S_RXNB] = evt_in.rx_desc_host;
    set_v[EDI_S_TXNB] = evt_in.tx_desc_host;
    set_v[EDI_S_BERR] = evt_in.bus_err;
    set_v[EDI_S_RWD]  = rwd_hit;
    set_v[EDI_S_JAB]  = jab_hit;
    set_v[EDI_S_PHY]  = st_r.phy_s2 & ~st_r.phy_prev;
    set_v[EDI_S_TS]   = evt_in.ts_evt |
                        (evt_in.ts_tgt & st_r.ts_tgt_en);
  end

  // Next state
  always_comb begin
    st_nxt = st_r;

    // PHY pin two-stage synchroniser
    st_nxt.phy_s1   = phy_irq_in;
    st_nxt.phy_s2   = st_r.phy_s1;

    // Edge memory of the synchronised level
    st_nxt.phy_prev = st_r.phy_s2;

    // Source and summary enables
    if (wr_en_reg) begin
      st_nxt.en = wr_data_in[16:0];
    end

    // DMA and process control
    if (wr_ctrl) begin
      st_nxt.dma_en = wr_data_in[EDI_C_DMA];
      st_nxt.tx_go  = wr_data_in[EDI_C_TXGO];
      st_nxt.rx_go  = wr_data_in[EDI_C_RXGO];
      st_nxt.jumbo  = wr_data_in[EDI_C_JUMBO];
    end

    // Timestamp target enable
    if (wr_tgt) begin
      st_nxt.ts_tgt_en = wr_data_in[0];
    end

    // Fatal bus error wins over a same-cycle enable write
    if (evt_in.bus_err) begin
      st_nxt.dma_en    = 1'b0;
      st_nxt.err_cause = evt_in.err_cause;
    end

    // Receive length counter
    if (evt_in.rx_end) begin
      st_nxt.rx_cnt = 14'h0000;
    end else if (rx_cnt_inc) begin
      st_nxt.rx_cnt = st_r.rx_cnt + 14'h0001;
    end

    // Transmit jabber counter
    if (evt_in.tx_end || jab_hit) begin
      st_nxt.tx_cnt = 14'h0000;
    end else if (tx_cnt_inc) begin
      st_nxt.tx_cnt = st_r.tx_cnt + 14'h0001;
    end

    // Abort pulse for the transmitter on jabber
    st_nxt.tx_abort = jab_hit;

    // Transmit process
    case (st_r.tx_p)
      // Start once go and DMA enable are stored; jabber holds stop
      EDI_PROC_STOP: begin
        if (st_r.tx_go && st_r.dma_en && !jab_hit) begin
          st_nxt.tx_p = EDI_PROC_RUN;
        end
      end
      // Jabber stops; underflow or host descriptor suspends
      EDI_PROC_RUN: begin
        if (jab_hit) begin
          st_nxt.tx_p = EDI_PROC_STOP;
        end else if (evt_in.tx_unf || evt_in.tx_desc_host) begin
          st_nxt.tx_p = EDI_PROC_SUSP;
        end
      end
      // Poll demand resumes a suspended transmitter
      EDI_PROC_SUSP: begin
        if (jab_hit) begin
          st_nxt.tx_p = EDI_PROC_STOP;
        end else if (poll_tx) begin
          st_nxt.tx_p = EDI_PROC_RUN;
        end
      end
      // Unused code falls back to stop
      default: begin
        st_nxt.tx_p = EDI_PROC_STOP;
      end
    endcase

    // Go or DMA enable cleared forces stop
    if (!st_nxt.tx_go || !st_nxt.dma_en) begin
      st_nxt.tx_p = EDI_PROC_STOP;
    end

    // Receive process
    case (st_r.rx_p)
      // Start once go and DMA enable are stored
      EDI_PROC_STOP: begin
        if (st_r.rx_go && st_r.dma_en) begin
          st_nxt.rx_p = EDI_PROC_RUN;
        end
      end
      // Host-owned descriptor suspends the receiver
      EDI_PROC_RUN: begin
        if (evt_in.rx_desc_host) begin
          st_nxt.rx_p = EDI_PROC_SUSP;
        end
      end
      // Poll demand resumes a suspended receiver
      EDI_PROC_SUSP: begin
        if (poll_rx) begin
          st_nxt.rx_p = EDI_PROC_RUN;
        end
      end
      // Unused code falls back to stop
      default: begin
        st_nxt.rx_p = EDI_PROC_STOP;
      end
    endcase

    // Go or DMA enable cleared forces stop
    if (!st_nxt.rx_go || !st_nxt.dma_en) begin
      st_nxt.rx_p = EDI_PROC_STOP;
    end

    // Sticky flags, set beats clear
    st_nxt.flag = flag_nxt;

    // Stopped flags on a run or suspend to stop change
    if (st_r.tx_p != EDI_PROC_STOP && st_nxt.tx_p == EDI_PROC_STOP) begin
      st_nxt.flag[EDI_S_TXS] = 1'b1;
    end
    if (st_r.rx_p != EDI_PROC_STOP && st_nxt.rx_p == EDI_PROC_STOP) begin
      st_nxt.flag[EDI_S_RXS] = 1'b1;
    end

    // Timestamp cause, read clears cause and flag
    if (rd_ts) begin
      st_nxt.ts_cause       = 4'h0;
      st_nxt.flag[EDI_S_TS] = set_v[EDI_S_TS];
    end

    // Cause bits gather until the next status read
    st_nxt.ts_cause = st_nxt.ts_cause |
                      (evt_in.ts_evt ? evt_in.ts_cause : 4'h0);

    // Processor request from enabled summaries and side sources
    st_nxt.irq = nrm_gated | abn_gated |
                 masked[EDI_S_PHY] | masked[EDI_S_TS];

    // Read data stands only in the cycle after the strobe
    st_nxt.rd_data = rd_en_in ? rd_mux : 32'h0000_0000;
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_r <= EDI_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign rd_data_out  = st_r.rd_data;
  assign irq_out      = st_r.irq;
  assign dma_en_out   = st_r.dma_en;
  assign tx_proc_out  = st_r.tx_p;
  assign rx_proc_out  = st_r.rx_p;
  assign tx_abort_out = st_r.tx_abort;
endmodule : edi_irq_logic

// File: dv/edi_irq_logic_asserts.sv
`timescale 1ns/1ps
module edi_irq_asserts (
  // Clock, reset and register port
  input wire logic          sys_clk_in,
  input wire logic          rst_n_in,
  input wire logic [7:0]    addr_in,
  input wire logic [31:0]   wr_data_in,
  input wire logic          wr_en_in,
  input wire logic          rd_en_in,
  input wire logic [31:0]   rd_data_out,
  // Events and outputs
  input edi_pkg::edi_evt_t  evt_in,
  input wire logic          phy_irq_in,
  input wire logic          irq_out,
  input wire logic          dma_en_out,
  input edi_pkg::edi_proc_t tx_proc_out,
  input edi_pkg::edi_proc_t rx_proc_out,
  input wire logic          tx_abort_out
);
  import edi_pkg::*;
  logic [16:0] en_r;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Shadow of the enable register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) en_r <= '0;
    else if (wr_en_in && addr_in == EDI_OFS_ENABLE) en_r <= wr_data_in[16:0];
  end
  // Process running with no register write or bus error
  sequence s_tx_run;
    tx_proc_out == EDI_PROC_RUN && !wr_en_in && !evt_in.bus_err;
  endsequence
  sequence s_rx_run;
    rx_proc_out == EDI_PROC_RUN && !wr_en_in && !evt_in.bus_err;
  endsequence
  property p_rd_zero;
    !$past(rd_en_in) |-> rd_data_out == '0;
  endproperty
  property p_naddr;
    rd_en_in && addr_in == EDI_OFS_NADDR |=> rd_data_out == {24'h00_0000, EDI_NUM_ADDR};
  endproperty
  property p_irq_en;
    irq_out |-> (en_r | $past(en_r)) != '0;
  endproperty
  property p_berr;
    evt_in.bus_err |=> !dma_en_out ##1 tx_proc_out == EDI_PROC_STOP;
  endproperty
  property p_unf;
    evt_in.tx_unf ##0 s_tx_run |=> tx_proc_out == EDI_PROC_SUSP;
  endproperty
  property p_txnb;
    evt_in.tx_desc_host ##0 s_tx_run |=> tx_proc_out == EDI_PROC_SUSP;
  endproperty
  property p_rxnb;
    evt_in.rx_desc_host ##0 s_rx_run |=> rx_proc_out == EDI_PROC_SUSP;
  endproperty
  property p_abort;
    tx_abort_out |-> tx_proc_out == EDI_PROC_STOP ##1 !tx_abort_out;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data off slot");
  a_naddr: assert property (p_naddr) else $error("slot count wrong");
  a_irq_en: assert property (p_irq_en) else $error("request with no enable");
  a_berr: assert property (p_berr) else $error("bus error kept dma");
  a_unf: assert property (p_unf) else $error("underflow no suspend");
  a_txnb: assert property (p_txnb) else $error("tx no suspend");
  a_rxnb: assert property (p_rxnb) else $error("rx no suspend");
  a_abort: assert property (p_abort) else $error("abort pulse wrong");
endmodule : edi_irq_asserts

bind edi_irq_logic edi_irq_asserts chk_u (.sys_clk_in, .rst_n_in, .addr_in, .wr_data_in,
  .wr_en_in, .rd_en_in, .rd_data_out, .evt_in, .phy_irq_in, .irq_out, .dma_en_out,
  .tx_proc_out, .rx_proc_out, .tx_abort_out);

// File: dv/tb_edi_irq_logic.sv
`timescale 1ns/1ps
module tb_edi_irq_logic;
  import edi_pkg::*;
  logic        sys_clk_in;
  logic        rst_n_in;
  logic [7:0]  addr_in;
  logic [31:0] wr_data_in;
  logic        wr_en_in;
  logic        rd_en_in;
  logic [31:0] rd_data_out;
  edi_evt_t    evt_in;
  logic        phy_irq_in;
  logic        irq_out;
  logic        dma_en_out;
  edi_proc_t   tx_proc_out;
  edi_proc_t   rx_proc_out;
  logic        tx_abort_out;
  int          err_count;
  int          tests_run;
  int          lim;
  edi_evt_t    ev;
  logic [31:0] ex [10] = '{32'h10001, 32'h10040, 32'h11000, 32'h8400, 32'h8010,
                           32'h8020, 32'h8080, 32'h10004, 32'h8800, 32'h4000};

  edi_irq_logic dut_u (.sys_clk_in, .rst_n_in, .addr_in, .wr_data_in, .wr_en_in,
    .rd_en_in, .rd_data_out, .evt_in, .phy_irq_in, .irq_out, .dma_en_out,
    .tx_proc_out, .rx_proc_out, .tx_abort_out);

  // Clock, 40 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic finish_test();
    if (err_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_en_in   <= 1'b1;
    @(posedge sys_clk_in);
    wr_en_in   <= 1'b0;
  endtask : wr

  // Data checked in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_in);
    addr_in  <= a;
    rd_en_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_en_in <= 1'b0;
    #1 chk(rd_data_out, e);
  endtask : rd

  task automatic pulse(input edi_evt_t e);
    @(posedge sys_clk_in);
    evt_in <= e;
    @(posedge sys_clk_in);
    evt_in <= '0;
  endtask : pulse

  function automatic edi_evt_t mk(input int k);
    mk = '0;
    case (k)
      0: mk.tx_wb_done = 1'b1;
      1: mk.rx_wb_done = 1'b1;
      2: mk.rx_first_buf = 1'b1;
      3: mk.tx_in_fifo = 1'b1;
      4: mk.rx_ovf = 1'b1;
      5: mk.tx_unf = 1'b1;
      6: mk.rx_desc_host = 1'b1;
      7: mk.tx_desc_host = 1'b1;
      8: mk.bus_err = 1'b1;
      default: mk.ts_evt = 1'b1;
    endcase
  endfunction : mk

  // Hang guard
  initial begin
    #2ms;
    err_count++;
    finish_test();
  end

  initial begin
    err_count = 0;
    tests_run = 0;
    rst_n_in = 1'b0;
    addr_in = '0;
    wr_data_in = '0;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    evt_in = '0;
    phy_irq_in = 1'b0;
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    rd(EDI_OFS_ENABLE, '0);
    wr(EDI_OFS_NADDR, 32'hFF);
    rd(EDI_OFS_NADDR, {24'h00_0000, EDI_NUM_ADDR});
    rd(8'h3C, '0);
    // Ten event sources: raw, masked, request, selective clear
    wr(EDI_OFS_ENABLE, 32'h1FFFF);
    for (int k = 0; k < 10; k++) begin
      pulse(mk(k));
      rd(EDI_OFS_RAW, ex[k]);
      rd(EDI_OFS_MASKED, ex[k]);
      chk(irq_out, 1'b1);
      wr(EDI_OFS_RAW, ex[k] & 32'h7FFF);
      rd(EDI_OFS_RAW, '0);
      chk(irq_out, 1'b0);
    end
    // Source masked off, then summary enable off
    wr(EDI_OFS_ENABLE, 32'h1FFFE);
    pulse(mk(0));
    rd(EDI_OFS_MASKED, '0);
    rd(EDI_OFS_RAW, 32'h1);
    chk(irq_out, 1'b0);
    wr(EDI_OFS_ENABLE, 32'h1FFFF);
    rd(EDI_OFS_MASKED, 32'h10001);
    chk(irq_out, 1'b1);
    wr(EDI_OFS_ENABLE, 32'hFFFF);
    rd(EDI_OFS_RAW, 32'h10001);
    chk(irq_out, 1'b0);
    wr(EDI_OFS_RAW, 32'h1);
    wr(EDI_OFS_ENABLE, 32'h0);
    // PHY pin level sets once
    phy_irq_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    rd(EDI_OFS_RAW, 32'h2000);
    wr(EDI_OFS_RAW, 32'h2000);
    rd(EDI_OFS_RAW, '0);
    // Timestamp cause and target enable
    ev = '0;
    ev.ts_evt = 1'b1;
    ev.ts_cause = 4'h5;
    pulse(ev);
    rd(EDI_OFS_TS_STAT, 32'h5);
    rd(EDI_OFS_RAW, '0);
    ev = '0;
    ev.ts_tgt = 1'b1;
    pulse(ev);
    rd(EDI_OFS_RAW, '0);
    wr(EDI_OFS_TS_TGT, 32'h1);
    pulse(ev);
    rd(EDI_OFS_RAW, 32'h4000);
    rd(EDI_OFS_TS_STAT, '0);
    // Suspend and poll resume
    wr(EDI_OFS_CTRL, 32'h7);
    rd(EDI_OFS_DMA_ST, 32'h5);
    pulse(mk(5));
    rd(EDI_OFS_DMA_ST, 32'h6);
    wr(EDI_OFS_POLL, 32'h1);
    pulse(mk(7));
    rd(EDI_OFS_DMA_ST, 32'h6);
    wr(EDI_OFS_POLL, 32'h1);
    pulse(mk(6));
    rd(EDI_OFS_DMA_ST, 32'h9);
    wr(EDI_OFS_POLL, 32'h2);
    rd(EDI_OFS_DMA_ST, 32'h5);
    rd(EDI_OFS_RAW, 32'hA4);
    wr(EDI_OFS_RAW, 32'h7FFF);
    // Fatal bus error
    ev = mk(8);
    ev.err_cause = 3'h5;
    pulse(ev);
    rd(EDI_OFS_DMA_ST, 32'h50);
    chk(dma_en_out, 1'b0);
    rd(EDI_OFS_RAW, 32'h902);
    rd(EDI_OFS_CTRL, 32'h6);
    // Jabber and watchdog, standard then jumbo
    for (int j = 0; j < 2; j++) begin
      wr(EDI_OFS_CTRL, 32'h0);
      wr(EDI_OFS_CTRL, 32'h7 | (j << 3));
      wr(EDI_OFS_RAW, 32'h7FFF);
      lim = j ? 10240 : 2048;
      ev = '0;
      ev.tx_byte = 1'b1;
      ev.rx_byte = 1'b1;
      evt_in <= ev;
      repeat (lim) @(posedge sys_clk_in);
      evt_in <= '0;
      rd(EDI_OFS_DMA_ST, 32'h55);
      rd(EDI_OFS_RAW, '0);
      pulse(ev);
      #1 chk(tx_proc_out, EDI_PROC_STOP);
      chk(tx_abort_out, 1'b1);
      rd(EDI_OFS_RAW, 32'h20A);
      ev = '0;
      ev.rx_end = 1'b1;
      ev.tx_end = 1'b1;
      pulse(ev);
    end
    finish_test();
  end
endmodule : tb_edi_irq_logic
